/* pkg/ptdc_map.svh */
`ifndef PTDC_MAP_SVH
`define PTDC_MAP_SVH
// ****************************************
// Widths and settings
// ****************************************
`define PTDC_POS_W 32
`define PTDC_WHEEL_W 8
`define PTDC_WHEEL_CENTRE 8'h80
`define PTDC_DEADBAND 8'h20
`define PTDC_BRIGHT_MAX 7'h64
`define PTDC_BRIGHT_MIN 7'h01
`define PTDC_TMO_MIN 9'h001
`define PTDC_TMO_MAX 9'h1E0
`define PTDC_TMO_NEVER 9'h1E1
`define PTDC_TMO_RST 9'h00A
`define PTDC_TMO_STEP1_TOP 9'h00A
`define PTDC_TMO_STEP10_TOP 9'h03C
`define PTDC_STEP_A 9'h001
`define PTDC_STEP_B 9'h00A
`define PTDC_STEP_C 9'h01E
// ****************************************
// Timing
// ****************************************
`define PTDC_CLK_HZ 50000000
`define PTDC_MIN_S 60
`define PTDC_MIN_CYC (64'(`PTDC_CLK_HZ) * `PTDC_MIN_S)
`define PTDC_FLASH_MS 250
`define PTDC_FLASH_CYC (`PTDC_CLK_HZ / 1000 * `PTDC_FLASH_MS)
// ****************************************
// Menu items and mode letters
// ****************************************
`define PTDC_ITEM_N 8
`define PTDC_CHR_V 8'h56
`define PTDC_CHR_P 8'h50
`define PTDC_CHR_J 8'h4A
`endif

/* pkg/ptdc_pkg.sv */
package ptdc_pkg;
  typedef enum logic [1:0] {
    PTDC_WM_VEL,
    PTDC_WM_TAUGHT,
    PTDC_WM_JOG
  } ptdc_wmode_t;
  typedef enum logic [2:0] {
    PTDC_IT_HOME,
    PTDC_IT_WMODE,
    PTDC_IT_TEACH,
    PTDC_IT_BRIGHT,
    PTDC_IT_TMO,
    PTDC_IT_DISABLE,
    PTDC_IT_STAGE,
    PTDC_IT_EXIT
  } ptdc_item_t;
  typedef enum logic [1:0] {
    PTDC_DIR_CTR,
    PTDC_DIR_UP,
    PTDC_DIR_DN
  } ptdc_dir_t;
endpackage : ptdc_pkg

/* verif/ptdc_panel_properties.sv */
`include "ptdc_map.svh"
module ptdc_panel_properties #(
  parameter int FLASH_CYC = 4
) (
  input wire logic ref_clk_i, // Clock
  input wire logic nrst_i, // Reset, low
  input wire logic [7:0] wheel_i, // Wheel
  input wire logic move_go_o, // Move start
  input wire logic home_drive_o, // Homing drive
  input wire logic pos_clr_o, // Counter clear
  input wire logic homed_led_o, // Homed lamp
  input wire logic [6:0] disp_level_o, // Brightness
  input wire logic [7:0] mode_chr_o, // Mode letter
  input wire logic menu_open_o, // Menu shown
  input wire logic stage_load_o, // Stage load
  input wire logic ready_o // Start-up done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic led_q;
  logic [7:0] stay_q;
  logic [7:0] stay_d;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // ****
  // Cycles the lamp holds still while homing
  // ****
  always_comb begin
    stay_d = (!home_drive_o || homed_led_o != led_q) ? 8'h00 : stay_q + 8'h01;
  end
  always_ff @(posedge ref_clk_i) begin
    led_q <= homed_led_o;
    stay_q <= nrst_i ? stay_d : 8'h00;
  end
  sequence s_cleared;
    pos_clr_o ##1 (homed_led_o && !home_drive_o);
  endsequence
  // ****
  // Properties
  // ****
  a_go_pulse: assert property (move_go_o |=> !move_go_o)
    else $error("move start held too long");
  a_go_taught: assert property (move_go_o |-> mode_chr_o == `PTDC_CHR_P)
    else $error("move outside taught mode");
  a_go_deflect: assert property (move_go_o |-> $past(wheel_i) <= 8'h60 || $past(wheel_i) >= 8'hA0)
    else $error("move without deflection");
  a_go_on_exit: assert property (move_go_o |-> $past(wheel_i, 2) > 8'h60 && $past(wheel_i, 2) < 8'hA0)
    else $error("move not on exit from centre");
  a_bright_max: assert property (disp_level_o <= `PTDC_BRIGHT_MAX)
    else $error("brightness above range");
  a_menu_lit: assert property (menu_open_o |-> disp_level_o != 7'h00)
    else $error("menu shown on dark display");
  a_mode_letter: assert property (mode_chr_o inside {`PTDC_CHR_V, `PTDC_CHR_P, `PTDC_CHR_J})
    else $error("bad mode letter");
  a_ready_hold: assert property (ready_o |=> ready_o)
    else $error("ready dropped");
  a_load_ready: assert property (stage_load_o |=> ready_o)
    else $error("no ready after stage load");
  a_clr_homed: assert property (pos_clr_o |-> $past(home_drive_o) ##0 s_cleared)
    else $error("clear not at end of homing");
  a_flash_rate: assert property (stay_q < FLASH_CYC + 2)
    else $error("lamp not flashing while homing");
  a_led_steady: assert property (!home_drive_o && !$past(home_drive_o) |-> $stable(homed_led_o))
    else $error("lamp changes outside homing");
endmodule : ptdc_panel_properties

/* verif/ptdc_stage_model.sv */
module ptdc_stage_model #(
  parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary value
) (
  input wire logic ref_clk_i, // Clock
  input wire logic home_drive_i, // Drive to home
  input wire logic pos_clr_i, // Counter clear
  input wire logic move_go_i, // Move start
  input wire logic signed [31:0] move_tgt_i, // Move target
  input wire logic set_en_i, // Manual placement
  input wire logic signed [31:0] set_pos_i, // Placement position
  input wire logic id_fit_i, // Identity element fitted
  output logic signed [31:0] pos_o, // Position
  output logic home_sw_o, // Home switch
  output logic move_done_o, // Move finished
  output logic id_valid_o, // Identity present
  output logic [7:0] id_code_o // Identity code
);
  timeunit 1ns;
  timeprecision 1ns;
  assign id_valid_o = id_fit_i;
  assign id_code_o = ID_CODE;
  initial begin
    pos_o = 32'sh0000_0100;
    home_sw_o = 1'b0;
    move_done_o = 1'b0;
  end
  // ****
  // Stage travel and home switch
  // ****
  always @(posedge ref_clk_i) begin
    if (pos_clr_i) pos_o <= 32'sh0;
    else if (set_en_i) pos_o <= set_pos_i;
    else if (move_go_i) pos_o <= move_tgt_i;
    else if (home_drive_i && pos_o > 32'sh0) pos_o <= pos_o - 32'sh1;
    home_sw_o <= pos_o == 32'sh0;
    move_done_o <= move_go_i;
  end
endmodule : ptdc_stage_model

/* verif/tb.sv */
`include "ptdc_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary value
  localparam int MINC = 10;
  logic ref_clk_i, nrst_i, btn_i, set_en, home_sw, move_done, id_valid, move_go, home_drive;
  logic pos_clr, homed_led, menu_open, stage_load, ready, id_fit;
  logic [7:0] wheel_i, id_code, stage_code, mode_chr, v;
  logic [6:0] host_dim, disp_level;
  logic signed [31:0] pos, set_pos, tgt, a1, a2;
  int compares, miscompares, gos, g, lds, cur;
  ptdc_panel #(.MIN_CYC(MINC), .FLASH_CYC(4)) i_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .btn_i(btn_i), .wheel_i(wheel_i), .pos_i(pos),
    .home_sw_i(home_sw), .move_done_i(move_done), .id_valid_i(id_valid), .id_code_i(id_code),
    .host_dim_i(host_dim), .move_go_o(move_go), .move_tgt_o(tgt), .home_drive_o(home_drive),
    .pos_clr_o(pos_clr), .homed_led_o(homed_led), .disp_level_o(disp_level),
    .mode_chr_o(mode_chr), .menu_open_o(menu_open), .stage_code_o(stage_code),
    .stage_load_o(stage_load), .ready_o(ready));
  ptdc_stage_model #(.ID_CODE(ID)) i_stage (
    .ref_clk_i(ref_clk_i), .home_drive_i(home_drive), .pos_clr_i(pos_clr),
    .move_go_i(move_go), .move_tgt_i(tgt), .set_en_i(set_en), .set_pos_i(set_pos),
    .id_fit_i(id_fit),
    .pos_o(pos), .home_sw_o(home_sw), .move_done_o(move_done), .id_valid_o(id_valid),
    .id_code_o(id_code));
  // ****
  // Helpers
  // ****
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) if (move_go === 1'b1) gos++;
  always @(posedge ref_clk_i) if (stage_load === 1'b1) lds++;
  task automatic cyc(int n); repeat (n) @(negedge ref_clk_i); endtask : cyc
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic press();
    btn_i = 1'b1;
    cyc(8);
    btn_i = 1'b0;
    cyc(8);
  endtask : press
  task automatic turn(logic [7:0] w);
    wheel_i = w;
    cyc(3);
    wheel_i = 8'h80;
    cyc(3);
  endtask : turn
  // Menu keeps its item between visits
  task automatic scroll(int n);
    repeat ((n - cur + 8) % 8) turn(8'hC0);
    cur = n;
  endtask : scroll
  task automatic open_item(int n);
    press();
    scroll(n);
    press();
  endtask : open_item
  task automatic setp(logic signed [31:0] p); set_pos = p; set_en = 1'b1; cyc(1); set_en = 1'b0; endtask : setp
  // Dimming lands the set minutes after the last press
  task automatic dim_chk(int m);
    cyc(m * MINC - 20);
    chk("level lit", disp_level, `PTDC_BRIGHT_MAX);
    cyc(12);
    chk("level dim", disp_level, host_dim);
  endtask : dim_chk
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // ****
  // Watchdog, several times the expected run
  // ****
  initial begin
    cyc(20000);
    miscompares++;
    wrap_up();
  end
  // ****
  // Tests
  // ****
  initial begin
    btn_i = 1'b0;
    wheel_i = 8'h80;
    host_dim = 7'h14;
    nrst_i = 1'b0;
    set_en = 1'b0;
    set_pos = 32'sh0;
    id_fit = 1'b1;
    cur = 0;
    void'($urandom(63196));
    cyc(2);
    nrst_i = 1'b1;
    repeat (50) if (ready !== 1'b1) cyc(1);
    chk("ready", ready, 1);
    chk("stage code", stage_code, ID);
    chk("mode letter", mode_chr, `PTDC_CHR_V);
    $display("boot test done");
    host_dim = 7'($urandom_range(1, 99));
    open_item(4);
    turn(8'h40);
    press();
    dim_chk(9);
    open_item(4);
    repeat (7) turn(8'hC0);
    repeat (2) turn(8'h40);
    press();
    dim_chk(50);
    $display("timeout test done");
    setp(32'sh28);
    open_item(0);
    chk("home drive", home_drive, 1);
    repeat (200) if (pos_clr !== 1'b1) cyc(1);
    chk("clear pulse", pos_clr, 1);
    cyc(1);
    chk("homed lamp", homed_led, 1);
    chk("position", pos, 0);
    $display("homing test done");
    open_item(1);
    turn(8'hC0);
    press();
    chk("mode letter", mode_chr, `PTDC_CHR_P);
    a1 = $urandom;
    setp(a1);
    open_item(2);
    press();
    chk("menu closed", menu_open, 0);
    a2 = $urandom;
    setp(a2);
    open_item(2);
    turn(8'hC0);
    press();
    chk("menu closed", menu_open, 0);
    for (int i = 0; i < 10; i++) begin
      v = i == 0 ? 8'h60 : i == 1 ? 8'hA0 : 8'($urandom);
      if (v > 8'h60 && v < 8'hA0) v = 8'h00;
      g = gos;
      wheel_i = v;
      repeat (10) if (gos == g) cyc(1);
      cyc(6);
      chk("move count", gos, g + 1);
      chk("target", tgt, v < 8'h80 ? a1 : a2);
      wheel_i = 8'h80;
      cyc(3);
    end
    g = gos;
    turn(8'h61);
    turn(8'h9F);
    chk("dead band", gos, g);
    $display("taught move test done");
    open_item(5);
    turn(8'hC0);
    press();
    g = gos;
    turn(8'h00);
    turn(8'hFF);
    chk("wheel disabled", gos, g);
    $display("disable test done");
    open_item(3);
    repeat (110) turn(8'h40);
    press();
    chk("display off", disp_level, 0);
    press();
    chk("display wake", disp_level, `PTDC_BRIGHT_MIN);
    scroll(7);
    press();
    chk("display off again", disp_level, 0);
    $display("brightness test done");
    chk("load pulses", lds, 1);
    nrst_i = 1'b0;
    id_fit = 1'b0;
    cyc(2);
    nrst_i = 1'b1;
    cyc(4);
    chk("ready before select", ready, 0);
    press();
    turn(8'hC0);
    turn(8'hC0);
    press();
    chk("ready after select", ready, 1);
    chk("manual stage code", stage_code, 8'h02);
    chk("load pulses", lds, 2);
    $display("manual stage test done");
    wrap_up();
  end
endmodule : tb
bind ptdc_panel ptdc_panel_properties #(.FLASH_CYC(FLASH_CYC)) i_prop (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wheel_i(wheel_i), .move_go_o(move_go_o),
  .home_drive_o(home_drive_o), .pos_clr_o(pos_clr_o), .homed_led_o(homed_led_o),
  .disp_level_o(disp_level_o), .mode_chr_o(mode_chr_o), .menu_open_o(menu_open_o),
  .stage_load_o(stage_load_o), .ready_o(ready_o));

/* verilog/ptdc_panel.sv */
`include "ptdc_map.svh"
module ptdc_panel #(
  parameter int POS_W = `PTDC_POS_W,
  parameter longint MIN_CYC = `PTDC_MIN_CYC,
  parameter int FLASH_CYC = `PTDC_FLASH_CYC
) (
  input wire logic ref_clk_i, // 50 MHz clock
  input wire logic nrst_i, // Sync reset, low
  input wire logic btn_i, // Select button pin
  input wire logic [7:0] wheel_i, // Wheel position, synchronous sample
  input wire logic signed [POS_W-1:0] pos_i, // Present encoder position
  input wire logic home_sw_i, // Home limit switch pin
  input wire logic move_done_i, // Motion controller done pulse
  input wire logic id_valid_i, // Stage identity present
  input wire logic [7:0] id_code_i, // Stage identity code
  input wire logic [6:0] host_dim_i, // Dim level from host
  output logic move_go_o, // Move start pulse
  output logic signed [POS_W-1:0] move_tgt_o, // Move target
  output logic home_drive_o, // Drive toward home switch
  output logic pos_clr_o, // Clear position counter pulse
  output logic homed_led_o, // Homed lamp
  output logic [6:0] disp_level_o, // Display brightness
  output logic [7:0] mode_chr_o, // Mode letter
  output logic menu_open_o, // Menu shown
  output logic [7:0] stage_code_o, // Loaded stage code
  output logic stage_load_o, // Stage parameter load pulse
  output logic ready_o // Start-up finished
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] btn_s_q, btn_s_d, hsw_s_q, hsw_s_d;
  logic btn_q, btn_d, hsw_q, hsw_d;
  always_comb begin
    btn_s_d = {btn_s_q[1:0], btn_i};
    hsw_s_d = {hsw_s_q[1:0], home_sw_i};
    btn_d = (btn_s_q[2] == btn_s_q[1]) ? btn_s_q[2] : btn_q;
    hsw_d = (hsw_s_q[2] == hsw_s_q[1]) ? hsw_s_q[2] : hsw_q;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      btn_s_q <= 3'h0;
      hsw_s_q <= 3'h0;
      btn_q <= 1'b0;
      hsw_q <= 1'b0;
    end else begin
      btn_s_q <= btn_s_d;
      hsw_s_q <= hsw_s_d;
      btn_q <= btn_d;
      hsw_q <= hsw_d;
    end
  end
  logic press;
  logic btn_old_q;
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) btn_old_q <= 1'b0;
    else btn_old_q <= btn_q;
  end
  assign press = btn_q & ~btn_old_q;
  // ****************************************
  // Wheel classification
  // ****************************************
  ptdc_pkg::ptdc_dir_t dir, dir_q;
  always_comb begin
    if (wheel_i >= `PTDC_WHEEL_CENTRE + `PTDC_DEADBAND) dir = ptdc_pkg::PTDC_DIR_UP;
    else if (wheel_i <= `PTDC_WHEEL_CENTRE - `PTDC_DEADBAND) dir = ptdc_pkg::PTDC_DIR_DN;
    else dir = ptdc_pkg::PTDC_DIR_CTR;
  end
  logic wup, wdn;
  assign wup = (dir == ptdc_pkg::PTDC_DIR_UP) && (dir_q == ptdc_pkg::PTDC_DIR_CTR);
  assign wdn = (dir == ptdc_pkg::PTDC_DIR_DN) && (dir_q == ptdc_pkg::PTDC_DIR_CTR);
  // ****************************************
  // Menu, settings, homing
  // ****************************************
  typedef enum logic [2:0] {ST_BOOT, ST_MAIN, ST_LIST, ST_EDIT, ST_HOMING} ptdc_st_t;
  ptdc_st_t st_q, st_d;
  ptdc_pkg::ptdc_item_t item_q, item_d;
  ptdc_pkg::ptdc_wmode_t wm_q, wm_d, ewm_q, ewm_d;
  logic signed [POS_W-1:0] t1_q, t1_d, t2_q, t2_d, tgt_q, tgt_d;
  logic [6:0] br_q, br_d, ebr_q, ebr_d;
  logic [8:0] tmo_q, tmo_d, etmo_q, etmo_d;
  logic slot_q, slot_d, dis_q, dis_d, edis_q, edis_d, homed_q, homed_d;
  logic go_q, go_d, clr_q, clr_d, ld_q, ld_d, rdy_q, rdy_d;
  logic [7:0] stg_q, stg_d;
  logic [8:0] stp_up, stp_dn;
  always_comb begin
    stp_up = (etmo_q < `PTDC_TMO_STEP1_TOP) ? `PTDC_STEP_A :
             (etmo_q < `PTDC_TMO_STEP10_TOP) ? `PTDC_STEP_B : `PTDC_STEP_C;
    stp_dn = (etmo_q <= `PTDC_TMO_STEP1_TOP) ? `PTDC_STEP_A :
             (etmo_q <= `PTDC_TMO_STEP10_TOP) ? `PTDC_STEP_B : `PTDC_STEP_C;
  end
  always_comb begin
    st_d = st_q; item_d = item_q; wm_d = wm_q; ewm_d = ewm_q;
    t1_d = t1_q; t2_d = t2_q; tgt_d = tgt_q; br_d = br_q; ebr_d = ebr_q;
    tmo_d = tmo_q; etmo_d = etmo_q; slot_d = slot_q; dis_d = dis_q;
    edis_d = edis_q; homed_d = homed_q; stg_d = stg_q; rdy_d = rdy_q;
    go_d = 1'b0; clr_d = 1'b0; ld_d = 1'b0;
    unique case (st_q)
      ST_BOOT: begin
        if (id_valid_i) begin
          stg_d = id_code_i;
          ld_d = 1'b1;
          rdy_d = 1'b1;
          st_d = ST_MAIN;
        end else if (press) begin
          item_d = ptdc_pkg::PTDC_IT_STAGE;
          st_d = ST_EDIT;
        end
      end
      ST_MAIN: begin
        if (press) st_d = ST_LIST;
        else if (!dis_q && wm_q == ptdc_pkg::PTDC_WM_TAUGHT) begin
          if (wdn) begin tgt_d = t1_q; go_d = 1'b1; end
          else if (wup) begin tgt_d = t2_q; go_d = 1'b1; end
        end
      end
      ST_LIST: begin
        if (wup) item_d = ptdc_pkg::ptdc_item_t'(item_q + 3'h1);
        else if (wdn) item_d = ptdc_pkg::ptdc_item_t'(item_q - 3'h1);
        if (press) begin
          ewm_d = wm_q; ebr_d = br_q; etmo_d = tmo_q; edis_d = dis_q; slot_d = 1'b0;
          if (item_q == ptdc_pkg::PTDC_IT_EXIT) st_d = ST_MAIN;
          else if (item_q == ptdc_pkg::PTDC_IT_HOME) begin
            homed_d = 1'b0;
            st_d = ST_HOMING;
          end else st_d = ST_EDIT;
        end
      end
      ST_EDIT: begin
        unique case (item_q)
          ptdc_pkg::PTDC_IT_WMODE: begin
            if (wup) ewm_d = (ewm_q == ptdc_pkg::PTDC_WM_JOG) ? ptdc_pkg::PTDC_WM_VEL :
                            ptdc_pkg::ptdc_wmode_t'(ewm_q + 2'h1);
            if (press) wm_d = ewm_q;
          end
          ptdc_pkg::PTDC_IT_TEACH: begin
            if (wup || wdn) slot_d = ~slot_q;
            if (press && !slot_q) t1_d = pos_i;
            if (press && slot_q) t2_d = pos_i;
          end
          ptdc_pkg::PTDC_IT_BRIGHT: begin
            if (wup && ebr_q < `PTDC_BRIGHT_MAX) ebr_d = ebr_q + 7'h01;
            else if (wdn && ebr_q != 7'h00) ebr_d = ebr_q - 7'h01;
            if (press) br_d = ebr_q;
          end
          ptdc_pkg::PTDC_IT_TMO: begin
            if (wup && etmo_q == `PTDC_TMO_MAX) etmo_d = `PTDC_TMO_NEVER;
            else if (wup && etmo_q < `PTDC_TMO_MAX) etmo_d = etmo_q + stp_up;
            else if (wdn && etmo_q == `PTDC_TMO_NEVER) etmo_d = `PTDC_TMO_MAX;
            else if (wdn && etmo_q > `PTDC_TMO_MIN) etmo_d = etmo_q - stp_dn;
            if (press) tmo_d = etmo_q;
          end
          ptdc_pkg::PTDC_IT_DISABLE: begin
            if (wup || wdn) edis_d = ~edis_q;
            if (press) dis_d = edis_q;
          end
          ptdc_pkg::PTDC_IT_STAGE: begin
            if (wup) stg_d = stg_q + 8'h01;
            else if (wdn) stg_d = stg_q - 8'h01;
            if (press) begin ld_d = 1'b1; rdy_d = 1'b1; end
          end
          default: ;
        endcase
        if (press) st_d = ST_MAIN;
      end
      ST_HOMING: begin
        if (press) st_d = ST_MAIN;
        else if (hsw_q) begin
          clr_d = 1'b1;
          homed_d = 1'b1;
          st_d = ST_MAIN;
        end
      end
      default: st_d = ST_BOOT;
    endcase
  end
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_q <= ST_BOOT; item_q <= ptdc_pkg::PTDC_IT_HOME;
      wm_q <= ptdc_pkg::PTDC_WM_VEL; ewm_q <= ptdc_pkg::PTDC_WM_VEL;
      t1_q <= '0; t2_q <= '0; tgt_q <= '0;
      br_q <= `PTDC_BRIGHT_MAX; ebr_q <= `PTDC_BRIGHT_MAX;
      tmo_q <= `PTDC_TMO_RST; etmo_q <= `PTDC_TMO_RST;
      slot_q <= 1'b0; dis_q <= 1'b0; edis_q <= 1'b0; homed_q <= 1'b0;
      go_q <= 1'b0; clr_q <= 1'b0; ld_q <= 1'b0; rdy_q <= 1'b0;
      stg_q <= 8'h00; dir_q <= ptdc_pkg::PTDC_DIR_CTR;
    end else begin
      st_q <= st_d; item_q <= item_d; wm_q <= wm_d; ewm_q <= ewm_d;
      t1_q <= t1_d; t2_q <= t2_d; tgt_q <= tgt_d; br_q <= br_d; ebr_q <= ebr_d;
      tmo_q <= tmo_d; etmo_q <= etmo_d; slot_q <= slot_d; dis_q <= dis_d;
      edis_q <= edis_d; homed_q <= homed_d; go_q <= go_d; clr_q <= clr_d;
      ld_q <= ld_d; rdy_q <= rdy_d; stg_q <= stg_d; dir_q <= dir;
    end
  end
  // ****************************************
  // Display timeout and flasher
  // ****************************************
  logic [31:0] cyc_q, cyc_d, fl_cnt_q, fl_cnt_d;
  logic [8:0] min_q, min_d;
  logic dim_q, dim_d, fl_q, fl_d, act;
  assign act = press | (dir != ptdc_pkg::PTDC_DIR_CTR);
  always_comb begin
    cyc_d = cyc_q; min_d = min_q; dim_d = dim_q;
    if (act) begin
      cyc_d = 32'h0; min_d = 9'h000; dim_d = 1'b0;
    end else if (tmo_q != `PTDC_TMO_NEVER && !dim_q) begin
      if (cyc_q == 32'(MIN_CYC - 1)) begin
        cyc_d = 32'h0;
        min_d = min_q + 9'h001;
        if (min_q + 9'h001 >= tmo_q) dim_d = 1'b1;
      end else cyc_d = cyc_q + 32'h1;
    end
    fl_d = fl_q;
    fl_cnt_d = fl_cnt_q + 32'h1;
    if (fl_cnt_q == 32'(FLASH_CYC - 1)) begin
      fl_cnt_d = 32'h0;
      fl_d = ~fl_q;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cyc_q <= 32'h0; min_q <= 9'h000; dim_q <= 1'b0;
      fl_cnt_q <= 32'h0; fl_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d; min_q <= min_d; dim_q <= dim_d;
      fl_cnt_q <= fl_cnt_d; fl_q <= fl_d;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  logic [6:0] lvl;
  always_comb begin
    if (br_q == 7'h00) lvl = (st_q == ST_LIST || st_q == ST_EDIT) ? `PTDC_BRIGHT_MIN : 7'h00;
    else if (dim_q) lvl = (host_dim_i < br_q) ? host_dim_i : br_q;
    else lvl = br_q;
  end
  assign disp_level_o = lvl;
  assign move_go_o = go_q;
  assign move_tgt_o = tgt_q;
  assign home_drive_o = (st_q == ST_HOMING);
  assign pos_clr_o = clr_q;
  assign homed_led_o = (st_q == ST_HOMING) ? fl_q : homed_q;
  assign mode_chr_o = (wm_q == ptdc_pkg::PTDC_WM_TAUGHT) ? `PTDC_CHR_P :
                      (wm_q == ptdc_pkg::PTDC_WM_JOG) ? `PTDC_CHR_J : `PTDC_CHR_V;
  assign menu_open_o = (st_q == ST_LIST || st_q == ST_EDIT);
  assign stage_code_o = stg_q;
  assign stage_load_o = ld_q;
  assign ready_o = rdy_q;
  logic unused;
  assign unused = move_done_i;
endmodule : ptdc_panel
